// *** verilog/pcs_pkg.sv ***
// shared constants and carriers for the port configuration strap decoder
package pcs_pkg;

  // ---------------------------------------------------------------
  // strap inputs and decoded settings
  // ---------------------------------------------------------------
  typedef struct packed {
    logic second_vc_enable_strap;
    logic rx_invert_detect_disable;
    logic large_payload_strap;
    logic common_refclk_strap;
  } pcs_strap_s;

  typedef struct packed {
    logic       vc1_enable;
    logic       vc1_buffers_to_vc0;
    logic       rx_invert_detect_enable;
    logic [2:0] max_payload_code;
    logic       common_refclk;
  } pcs_cfg_s;

  localparam pcs_strap_s STRAP_RST = 4'h0;

  // max payload capability field encodings
  localparam logic [2:0] MPS_256B = 3'h1;
  localparam logic [2:0] MPS_512B = 3'h2;

  // ---------------------------------------------------------------
  // pin synchroniser layout
  // ---------------------------------------------------------------
  localparam int          SYNC_W       = 8;
  localparam int          SYNC_STRAP_LSB = 4;
  localparam int          SYNC_OCC_LSB = 2;
  localparam int          SYNC_IMP_LSB = 0;
  localparam logic [7:0]  SYNC_RST     = 8'h0C;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int         ADR_W       = 8;
  localparam logic [7:0] OFS_STRAP   = 8'h00;
  localparam logic [7:0] OFS_SLOT    = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_PLUG    = 8'h0C;

  // strap register fields
  localparam int STRAP_VALID_BIT = 4;
  // slot register fields
  localparam int SLOT_OCC_LSB    = 0;
  localparam int SLOT_IMPLEMENTED_LSB    = 2;
  localparam int SLOT_RST_LSB    = 4;
  // control register fields
  localparam int CTRL_FORCE_LSB  = 0;
  localparam int CTRL_OVR_BIT    = 2;
  localparam int CTRL_OVR_LSB    = 3;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLUG_RST_NS   = 1000;
  localparam int PLUG_RST_CYC  = (PLUG_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLUG_CNT_W    = 7;

endpackage

// *** verilog/pcs_sync.sv ***
// two-stage synchroniser for board-level inputs
`timescale 1ns/1ps

module pcs_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous pins and synchronised copy
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;

  // first stage feeds only the second stage
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      always_comb begin
        next_meta[b]   = rst_i ? RST_VAL[b] : async_i[b];
        next_stable[b] = rst_i ? RST_VAL[b] : meta[b];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    meta   <= next_meta;
    stable <= next_stable;
  end

  assign sync_o = stable;

endmodule

// *** verilog/pcs_strap_decode.sv ***
// strap decode, slot tracking and downstream reset for a three-port switch
//
// Contract
// - strap high: vc1 enabled, no sharing
// - strap low: vc1 off, buffers to vc0
// - disable strap high turns inversion detect off
// - payload strap selects 512B or 256B capability
// - presence inputs active low per port
// - refclk strap high: common platform reference clock
// - slot implemented input marks port slotted
// - one debug status bit per port
// - reset clears all but sticky state
// - downstream reset during system reset, plug-in
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps

module pcs_strap_decode (
  // clock and resets
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                power_on_rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // board pins
  input  wire pcs_pkg::pcs_strap_s straps_i,
  input  wire logic [2:1]          slot_occupied_n_i,
  input  wire logic [2:1]          slot_implemented_i,
  // decoded settings and board outputs
  output pcs_pkg::pcs_cfg_s        cfg_o,
  output logic      [2:1]          slot_present_o,
  output logic      [2:1]          slot_connected_o,
  output logic      [2:1]          downstream_reset_n_o,
  output logic      [2:0]          port_status_o
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [7:0] pins_sync;

  pcs_sync #(
    .W       (pcs_pkg::SYNC_W),
    .RST_VAL (pcs_pkg::SYNC_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({straps_i, slot_occupied_n_i, slot_implemented_i}),
    .sync_o  (pins_sync)
  );

  pcs_pkg::pcs_strap_s strap_sync;
  logic [2:1]          occ_sync;
  logic [2:1]          imp_sync;

  assign strap_sync = pins_sync[pcs_pkg::SYNC_STRAP_LSB +: 4];
  assign occ_sync   = ~pins_sync[pcs_pkg::SYNC_OCC_LSB +: 2];
  assign imp_sync   = pins_sync[pcs_pkg::SYNC_IMP_LSB +: 2];

  // ---------------------------------------------------------------
  // strap latch sequence
  // ---------------------------------------------------------------
  // wait for the synchroniser to refill before trusting the straps
  typedef enum logic [1:0] {ST_FILL0, ST_FILL1, ST_FILL2, ST_RUN} pcs_state_e;

  pcs_state_e          state;
  pcs_state_e          next_state;
  pcs_pkg::pcs_strap_s strap;
  pcs_pkg::pcs_strap_s next_strap;

  always_comb begin
    next_state = state;
    next_strap = strap;
    case (state)
      ST_FILL0: next_state = ST_FILL1;
      ST_FILL1: next_state = ST_FILL2;
      ST_FILL2: begin
        next_state = ST_RUN;
        next_strap = strap_sync;
      end
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_FILL0;
    endcase
    if (rst_i) begin
      next_state = ST_FILL0;
      next_strap = pcs_pkg::STRAP_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
    strap <= next_strap;
  end

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  pcs_pkg::pcs_cfg_s next_cfg;

  always_comb begin
    next_cfg.vc1_enable              = strap.second_vc_enable_strap;
    next_cfg.vc1_buffers_to_vc0      = ~strap.second_vc_enable_strap;
    next_cfg.rx_invert_detect_enable = ~strap.rx_invert_detect_disable;
    next_cfg.max_payload_code        = strap.large_payload_strap ?
                                       pcs_pkg::MPS_512B : pcs_pkg::MPS_256B;
    next_cfg.common_refclk           = strap.common_refclk_strap;
  end

  always_ff @(posedge clk_i) begin
    cfg_o <= next_cfg;
  end

  // ---------------------------------------------------------------
  // slot tracking, plug events and downstream reset
  // ---------------------------------------------------------------
  logic [5:0] ctrl;
  logic [2:1] occ_prev;
  logic [2:1] next_occ_prev;
  logic [2:1] plug_event;
  logic [2:1] plug_sticky;
  logic [2:1] next_plug_sticky;
  logic [2:1] plug_clr;
  logic [2:1] next_present;
  logic [2:1] next_connected;
  logic [2:1] next_dsrst_n;

  logic [pcs_pkg::PLUG_CNT_W-1:0] plug_cnt [2:1];
  logic [pcs_pkg::PLUG_CNT_W-1:0] next_plug_cnt [2:1];

  genvar p;
  generate
    for (p = 1; p <= 2; p++) begin : g_port
      always_comb begin
        next_occ_prev[p]  = rst_i ? 1'b0 : occ_sync[p];
        plug_event[p]     = (state == ST_RUN) & occ_sync[p] & ~occ_prev[p];
        next_present[p]   = rst_i ? 1'b0 : occ_sync[p];
        next_connected[p] = rst_i ? 1'b0 : imp_sync[p];
        // plug-in stretches downstream reset for a fixed time
        if (rst_i) begin
          next_plug_cnt[p] = '0;
        end else if (plug_event[p]) begin
          next_plug_cnt[p] = pcs_pkg::PLUG_CNT_W'(pcs_pkg::PLUG_RST_CYC);
        end else if (plug_cnt[p] != '0) begin
          next_plug_cnt[p] = plug_cnt[p] - 1'b1;
        end else begin
          next_plug_cnt[p] = plug_cnt[p];
        end
        next_dsrst_n[p] = ~(rst_i | plug_event[p] | (plug_cnt[p] != '0)
                            | ctrl[pcs_pkg::CTRL_FORCE_LSB + p - 1]);
        // sticky flag survives system reset; set wins over clear
        if (power_on_rst_i) begin
          next_plug_sticky[p] = 1'b0;
        end else if (plug_event[p]) begin
          next_plug_sticky[p] = 1'b1;
        end else if (plug_clr[p]) begin
          next_plug_sticky[p] = 1'b0;
        end else begin
          next_plug_sticky[p] = plug_sticky[p];
        end
      end

      always_ff @(posedge clk_i) begin
        occ_prev[p]             <= next_occ_prev[p];
        plug_cnt[p]             <= next_plug_cnt[p];
        plug_sticky[p]          <= next_plug_sticky[p];
        slot_present_o[p]       <= next_present[p];
        slot_connected_o[p]     <= next_connected[p];
        downstream_reset_n_o[p] <= next_dsrst_n[p];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // debug port status
  // ---------------------------------------------------------------
  logic [2:0] next_status;

  always_comb begin
    if (rst_i) begin
      next_status = 3'h0;
    end else if (ctrl[pcs_pkg::CTRL_OVR_BIT]) begin
      next_status = ctrl[pcs_pkg::CTRL_OVR_LSB +: 3];
    end else begin
      next_status[0] = (state == ST_RUN);
      next_status[2:1] = slot_present_o & slot_connected_o & downstream_reset_n_o;
    end
  end

  always_ff @(posedge clk_i) begin
    port_status_o <= next_status;
  end

  // ---------------------------------------------------------------
  // wishbone register slave
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  logic        req;
  logic        wr0;
  logic [5:0]  next_ctrl;
  logic        next_ack;
  logic [31:0] next_dat;

  // one access per request; ack drops the cycle after it rises
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr0 = req & wb_we_i & wb_sel_i[0];

  always_comb begin
    next_ctrl = ctrl;
    if (wr0 && reg_hit(wb_adr_i, pcs_pkg::OFS_CTRL)) begin
      next_ctrl = wb_dat_i[5:0];
    end
    if (rst_i) begin
      next_ctrl = pcs_pkg::CTRL_RST;
    end
    plug_clr = (wr0 && reg_hit(wb_adr_i, pcs_pkg::OFS_PLUG)) ? wb_dat_i[1:0] : 2'h0;
    next_ack = req & ~rst_i;
    next_dat = 32'h0;
    if (req && !wb_we_i) begin
      if (reg_hit(wb_adr_i, pcs_pkg::OFS_STRAP)) begin
        next_dat[3:0] = strap;
        next_dat[pcs_pkg::STRAP_VALID_BIT] = (state == ST_RUN);
      end else if (reg_hit(wb_adr_i, pcs_pkg::OFS_SLOT)) begin
        next_dat[pcs_pkg::SLOT_OCC_LSB +: 2] = slot_present_o;
        next_dat[pcs_pkg::SLOT_IMPLEMENTED_LSB +: 2] = slot_connected_o;
        next_dat[pcs_pkg::SLOT_RST_LSB +: 2] = ~downstream_reset_n_o;
      end else if (reg_hit(wb_adr_i, pcs_pkg::OFS_CTRL)) begin
        next_dat[5:0] = ctrl;
      end else if (reg_hit(wb_adr_i, pcs_pkg::OFS_PLUG)) begin
        next_dat[1:0] = plug_sticky;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    ctrl     <= next_ctrl;
    wb_ack_o <= next_ack;
    wb_dat_o <= next_dat;
  end

endmodule

// *** verif/pcs_board.sv ***
// board model: strap resistors and slot contacts
`timescale 1ns/1ps
module pcs_board (
  // settings chosen by the bench
  input  wire logic [3:0]     strap_set_i,
  input  wire logic [2:1]     card_i,
  input  wire logic [2:1]     slot_i,
  // pins toward the switch
  output pcs_pkg::pcs_strap_s straps_o,
  output logic      [2:1]     slot_occupied_n_o,
  output logic      [2:1]     slot_implemented_o
);
  // a fitted card grounds its presence contact
  assign slot_occupied_n_o  = ~card_i;
  assign slot_implemented_o = slot_i;
  assign straps_o           = strap_set_i;
endmodule

// *** verif/pcs_strap_decode_props.sv ***
// port assertions for the strap decoder
`timescale 1ns/1ps
module pcs_strap_decode_chk (
  // clock, reset and bus
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  // pins and decoded outputs
  input wire pcs_pkg::pcs_strap_s straps_i,
  input wire logic [2:1]          slot_occupied_n_i,
  input wire logic [2:1]          slot_implemented_i,
  input wire pcs_pkg::pcs_cfg_s   cfg_o,
  input wire logic [2:1]          slot_present_o,
  input wire logic [2:1]          slot_connected_o,
  input wire logic [2:1]          downstream_reset_n_o,
  input wire logic [2:0]          port_status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_vc_decode: assert property ($fell(rst_i) |-> ##6
    cfg_o.vc1_enable == straps_i.second_vc_enable_strap
    && cfg_o.vc1_buffers_to_vc0 != straps_i.second_vc_enable_strap) else $error("vc setting");
  a_payload_decode: assert property ($fell(rst_i) |-> ##6 cfg_o.max_payload_code ==
    (straps_i.large_payload_strap ? pcs_pkg::MPS_512B : pcs_pkg::MPS_256B))
    else $error("payload setting");
  a_inv_refclk_decode: assert property ($fell(rst_i) |-> ##6
    cfg_o.rx_invert_detect_enable != straps_i.rx_invert_detect_disable
    && cfg_o.common_refclk == straps_i.common_refclk_strap) else $error("inversion or refclk");
  a_present_lag: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> slot_present_o == ~$past(slot_occupied_n_i, 3)) else $error("presence lag");
  a_connected_lag: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> slot_connected_o == $past(slot_implemented_i, 3)) else $error("slot lag");
  a_plug_reset: assert property ($rose(slot_present_o[1]) |-> ##2
    (!downstream_reset_n_o[1]) [*8]) else $error("no reset after plug-in");
  a_reset_clears: assert property ($fell(rst_i) |-> downstream_reset_n_o == 2'h0
    && port_status_o == 3'h0) else $error("outputs not cleared by reset");
  a_status_run: assert property ($fell(rst_i) |-> ##5 port_status_o[0])
    else $error("port 0 status not up");
endmodule

bind pcs_strap_decode pcs_strap_decode_chk pcs_strap_decode_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .straps_i(straps_i), .slot_occupied_n_i(slot_occupied_n_i),
  .slot_implemented_i(slot_implemented_i), .cfg_o(cfg_o), .slot_present_o(slot_present_o),
  .slot_connected_o(slot_connected_o), .downstream_reset_n_o(downstream_reset_n_o),
  .port_status_o(port_status_o));

// *** verif/pcs_strap_decode_test.sv ***
// self-checking bench for the strap decoder
`timescale 1ns/1ps
module pcs_strap_decode_test;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                por = 1'b1;
  logic                cyc = 1'b0;
  logic                stb = 1'b0;
  logic                we = 1'b0;
  logic                ack;
  logic [7:0]          adr = 8'h00;
  logic [3:0]          sel = 4'h0;
  logic [3:0]          strap_set = 4'h0;
  logic [31:0]         wdat = 32'h0;
  logic [31:0]         rdat;
  logic [31:0]         q;
  logic [2:1]          card = 2'h0;
  logic [2:1]          slot = 2'h3;
  logic [2:1]          occ_n, imp, present, connected, drn;
  logic [2:0]          status;
  logic [6:0]          exp_cfg;
  logic [3:0]          pat [2] = '{4'hA, 4'h5};
  pcs_pkg::pcs_strap_s straps;
  pcs_pkg::pcs_cfg_s   cfg;
  int                  fail_count = 0;
  int                  compares = 0;

  pcs_board pcs_board_inst (.strap_set_i(strap_set), .card_i(card), .slot_i(slot),
    .straps_o(straps), .slot_occupied_n_o(occ_n), .slot_implemented_o(imp));
  pcs_strap_decode pcs_strap_decode_inst (.clk_i(clk_i), .rst_i(rst_i), .power_on_rst_i(por),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .straps_i(straps),
    .slot_occupied_n_i(occ_n), .slot_implemented_i(imp), .cfg_o(cfg),
    .slot_present_o(present), .slot_connected_o(connected),
    .downstream_reset_n_o(drn), .port_status_o(status));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h got %h", what, exp, got);
      fail_count++;
    end
  endtask

  // one classic cycle; waits for ack, bounded
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) check("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    check(what, exp, q);
  endtask

  task automatic do_reset(input logic [3:0] s);
    @(posedge clk_i);
    rst_i     <= 1'b1;
    strap_set <= s;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    por   <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    conclude;
  end

  initial begin
    foreach (pat[i]) begin
      do_reset(pat[i]);
      exp_cfg = {pat[i][3], ~pat[i][3], ~pat[i][2],
                 pat[i][1] ? pcs_pkg::MPS_512B : pcs_pkg::MPS_256B, pat[i][0]};
      check("cfg", {25'h0, exp_cfg}, {25'h0, cfg});
      rd_chk("strap", pcs_pkg::OFS_STRAP, {27'h0, 1'b1, pat[i]});
      $display("strap test %0d done", i);
    end
    check("connected", 32'h3, {30'h0, connected});
    check("status idle", 32'h1, {29'h0, status});
    rd_chk("slot", pcs_pkg::OFS_SLOT, 32'h0C);
    @(posedge clk_i);
    card <= 2'h1;
    repeat (6) @(posedge clk_i);
    check("present", 32'h1, {30'h0, present});
    check("plug reset", 32'h2, {30'h0, drn});
    rd_chk("plug flag", pcs_pkg::OFS_PLUG, 32'h1);
    xfer(1'b1, pcs_pkg::OFS_PLUG, 32'h1, 4'hF);
    rd_chk("plug clear", pcs_pkg::OFS_PLUG, 32'h0);
    repeat (110) @(posedge clk_i);
    check("reset release", 32'h3, {30'h0, drn});
    check("status run", 32'h3, {29'h0, status});
    $display("slot test done");
    // lane 0 disabled: write must not land
    xfer(1'b1, pcs_pkg::OFS_CTRL, 32'h3E, 4'hE);
    rd_chk("ctrl lane off", pcs_pkg::OFS_CTRL, 32'h0);
    xfer(1'b1, pcs_pkg::OFS_CTRL, 32'h3E, 4'h1);
    rd_chk("ctrl", pcs_pkg::OFS_CTRL, 32'h3E);
    check("forced reset", 32'h1, {30'h0, drn});
    check("status override", 32'h7, {29'h0, status});
    rd_chk("unmapped", 8'h10, 32'h0);
    xfer(1'b1, pcs_pkg::OFS_CTRL, 32'h0, 4'h1);
    $display("control test done");
    // straps move after the latch; port 2 plugged into an unimplemented slot
    @(posedge clk_i);
    card      <= 2'h2;
    slot      <= 2'h1;
    strap_set <= ~pat[1];
    repeat (6) @(posedge clk_i);
    check("cfg hold", {25'h0, exp_cfg}, {25'h0, cfg});
    check("plug reset 2", 32'h1, {30'h0, drn});
    check("status 2", 32'h1, {29'h0, status});
    card <= 2'h0;
    repeat (4) @(posedge clk_i);
    // sticky flag must outlive a system reset
    do_reset(pat[1]);
    rd_chk("sticky", pcs_pkg::OFS_PLUG, 32'h2);
    rd_chk("slot impl", pcs_pkg::OFS_SLOT, 32'h04);
    $display("sticky test done");
    conclude;
  end
endmodule
